//--- rtl/dcwd_device.sv
// Decoder end: command word register, decode, channel report, energy counters
`timescale 1ns/1ns
module dcwd_device (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register link
  dcwd_link_if.dev link,
  // Configuration
  input wire logic [1:0] ctrl_mode_i,
  input wire logic io_three_wire_i,
  input wire logic [1:0] cmd_channel_sel_i,
  input wire logic [1:0] ref_channel_sel_i,
  input wire logic [1:0] word_channel_i,
  input wire logic fieldbus_present_i,
  // Measurements
  input wire logic energy_wh_tick_i,
  input wire logic [15:0] pre_ramp_ref_i,
  // CiA402 commands
  output logic switch_on_o,
  output logic voltage_enable_o,
  output logic quick_stop_o,
  output logic enable_op_o,
  output logic fault_ack_o,
  output logic halt_o,
  // I/O profile commands
  output logic io_forward_o,
  output logic io_run_auth_o,
  // Raw word for assignable bits
  output logic [15:0] user_bits_o
);
  typedef struct packed {
    logic [15:0] word;
    logic [15:0] prev;
    logic fb_meta;
    logic fb_sync;
    logic ack;
    logic [15:0] rdata;
    logic [15:0] ref_val;
    logic [1:0] cmd_src;
    logic [1:0] ref_src;
    logic switch_on;
    logic voltage_en;
    logic quick_stop;
    logic enable_op;
    logic fault_ack;
    logic halt;
    logic io_forward;
    logic io_run_auth;
  } dcwd_dev_state_t;

  dcwd_dev_state_t state_q;
  dcwd_dev_state_t state_d;

  logic [9:0] energy [4];
  logic [4:0] carry;

  // ---------------------------------------------------------------
  // Energy counters, Wh stage first
  // ---------------------------------------------------------------
  assign carry[0] = energy_wh_tick_i;

  for (genvar g = 0; g < 4; g++) begin : g_energy
    dcwd_energy_digit #(
      .MAX_COUNT(dcwd_pkg::ENERGY_MAX)
    ) u_digit (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .inc_i(carry[g]),
      .count_o(energy[g]),
      .carry_o(carry[g+1])
    );
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [15:0] rise;
    logic io_mode;
    logic chan_active;
    logic [1:0] cmd_src;
    logic [1:0] ref_src;
    rise = 16'h0000;
    io_mode = 1'b0;
    chan_active = 1'b0;
    cmd_src = cmd_channel_sel_i;
    ref_src = ref_channel_sel_i;
    state_d = state_q;

    // Presence pin is asynchronous to this clock
    state_d.fb_meta = fieldbus_present_i;
    state_d.fb_sync = state_q.fb_meta;
    state_d.ref_val = pre_ramp_ref_i;

    // absent module falls back to terminals
    if (cmd_src == 2'(dcwd_pkg::FIELDBUS_MODULE_SOURCE) && !state_q.fb_sync) begin
      cmd_src = 2'(dcwd_pkg::TERMINAL_BLOCK_SOURCE);
    end
    if (ref_src == 2'(dcwd_pkg::FIELDBUS_MODULE_SOURCE) && !state_q.fb_sync) begin
      ref_src = 2'(dcwd_pkg::TERMINAL_BLOCK_SOURCE);
    end
    state_d.cmd_src = cmd_src;
    state_d.ref_src = ref_src;

    // Link access: one ack per request, dropped the next cycle
    state_d.ack = 1'b0;
    if (link.req && !state_q.ack) begin
      state_d.ack = 1'b1;
      if (link.we && link.addr == dcwd_pkg::REG_COMMAND_WORD) begin
        state_d.word = link.wdata;
      end
      unique case (link.addr)
        dcwd_pkg::REG_ENERGY_GWH: state_d.rdata = {6'h00, energy[3]};
        dcwd_pkg::REG_ENERGY_MWH: state_d.rdata = {6'h00, energy[2]};
        dcwd_pkg::REG_ENERGY_KWH: state_d.rdata = {6'h00, energy[1]};
        dcwd_pkg::REG_ENERGY_WH: state_d.rdata = {6'h00, energy[0]};
        dcwd_pkg::REG_CMD_SOURCE: state_d.rdata = {14'h0000, state_q.cmd_src};
        dcwd_pkg::REG_COMMAND_WORD: state_d.rdata = state_q.word;
        dcwd_pkg::REG_REF_SOURCE: state_d.rdata = {14'h0000, state_q.ref_src};
        dcwd_pkg::REG_PRE_RAMP_REF: state_d.rdata = state_q.ref_val;
      endcase
    end

    state_d.prev = state_q.word;
    rise = state_q.word & ~state_q.prev;

    // anything but I/O profile is CiA402
    io_mode = (ctrl_mode_i == dcwd_pkg::CTRL_IO_PROFILE);
    // fixed bits need the active channel
    chan_active = (word_channel_i == state_q.cmd_src);

    state_d.switch_on = 1'b0;
    state_d.voltage_en = 1'b0;
    state_d.quick_stop = 1'b0;
    state_d.enable_op = 1'b0;
    state_d.fault_ack = 1'b0;
    state_d.halt = 1'b0;
    state_d.io_forward = 1'b0;
    state_d.io_run_auth = 1'b0;

    if (!io_mode) begin
      state_d.switch_on = state_q.word[dcwd_pkg::BIT_SWITCH_ON];
      state_d.voltage_en = state_q.word[dcwd_pkg::BIT_VOLTAGE];
      state_d.quick_stop = ~state_q.word[dcwd_pkg::BIT_QUICK_STOP];
      state_d.enable_op = state_q.word[dcwd_pkg::BIT_ENABLE_OP];
      state_d.fault_ack = rise[dcwd_pkg::BIT_FAULT_RESET];
      state_d.halt = state_q.word[dcwd_pkg::BIT_HALT];
    end else if (chan_active) begin
      // fixed terminal mapping of low bits
      if (!io_three_wire_i) begin
        state_d.io_forward = state_q.word[dcwd_pkg::BIT_IO_FORWARD_2W];
      end else begin
        state_d.io_run_auth = state_q.word[dcwd_pkg::BIT_IO_RUN_AUTH];
        state_d.io_forward = rise[dcwd_pkg::BIT_IO_FORWARD_3W] & state_q.word[dcwd_pkg::BIT_IO_RUN_AUTH];
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= '0;
      state_q.word <= dcwd_pkg::COMMAND_WORD_RESET;
      state_q.prev <= dcwd_pkg::COMMAND_WORD_RESET;
      state_q.cmd_src <= 2'(dcwd_pkg::TERMINAL_BLOCK_SOURCE);
      state_q.ref_src <= 2'(dcwd_pkg::TERMINAL_BLOCK_SOURCE);
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign link.ack = state_q.ack;
  assign link.rdata = state_q.rdata;
  assign switch_on_o = state_q.switch_on;
  assign voltage_enable_o = state_q.voltage_en;
  assign quick_stop_o = state_q.quick_stop;
  assign enable_op_o = state_q.enable_op;
  assign fault_ack_o = state_q.fault_ack;
  assign halt_o = state_q.halt;
  assign io_forward_o = state_q.io_forward;
  assign io_run_auth_o = state_q.io_run_auth;
  // Assignable bits are passed raw; their use lies outside this block
  assign user_bits_o = state_q.word;
endmodule : dcwd_device

//--- rtl/dcwd_pkg.sv
// Constants and types shared by both ends of the drive command word decoder
// Notes on behaviour
// - Four energy counters, each 0 to 999
// - Command source encodes four channels, terminals default
// - Fieldbus reported only when module present
// - Non-I/O control modes use CiA402 layout
// - Master sets bit 0 for switch-on
// - Bit 1 low disables voltage
// - Bit 2 low requests quick stop
// - Bit 3 high enables operation, runs
// - Fault acknowledged on bit 7 rising edge
// - Bit 8 high halts, stays operation enabled
// - Master keeps reserved bits zero (host clears them only when its CiA402 control bit is set)
// - Two-wire bit 0 is forward level
// - Fixed low bits follow terminals, not remappable
// - Fixed bits act only on active channel
// - Three-wire bit 0 is run authorization
// - Three-wire forward on bit 1 rising edge
// - Reference channel uses same four-source encoding
package dcwd_pkg;

  // ---------------------------------------------------------------
  // Widths and link register map
  // ---------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 3;
  localparam int ENERGY_W = 10;
  localparam logic [2:0] REG_ENERGY_GWH = 3'h0;
  localparam logic [2:0] REG_ENERGY_MWH = 3'h1;
  localparam logic [2:0] REG_ENERGY_KWH = 3'h2;
  localparam logic [2:0] REG_ENERGY_WH = 3'h3;
  localparam logic [2:0] REG_CMD_SOURCE = 3'h4;
  localparam logic [2:0] REG_COMMAND_WORD = 3'h5;
  localparam logic [2:0] REG_REF_SOURCE = 3'h6;
  localparam logic [2:0] REG_PRE_RAMP_REF = 3'h7;
  localparam logic [15:0] COMMAND_WORD_RESET = 16'h0000;
  localparam logic [9:0] ENERGY_MAX = 10'h3e7;
  localparam logic [9:0] ENERGY_RESET = 10'h000;

  // ---------------------------------------------------------------
  // Command word fields
  // ---------------------------------------------------------------
  localparam int BIT_SWITCH_ON = 0;
  localparam int BIT_VOLTAGE = 1;
  localparam int BIT_QUICK_STOP = 2;
  localparam int BIT_ENABLE_OP = 3;
  localparam int BIT_FAULT_RESET = 7;
  localparam int BIT_HALT = 8;
  localparam int BIT_IO_FORWARD_2W = 0;
  localparam int BIT_IO_RUN_AUTH = 0;
  localparam int BIT_IO_FORWARD_3W = 1;
  localparam logic [15:0] RESERVED_MASK = 16'h0670;

  // ---------------------------------------------------------------
  // Channels and control modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TERMINAL_BLOCK_SOURCE = 2'h0,
    REMOTE_DISPLAY_SOURCE = 2'h1,
    MODBUS_SOURCE = 2'h2,
    FIELDBUS_MODULE_SOURCE = 2'h3
  } dcwd_src_t;
  localparam logic [1:0] CTRL_CIA402_SEP = 2'h0;
  localparam logic [1:0] CTRL_CIA402_NSEP = 2'h1;
  localparam logic [1:0] CTRL_IO_PROFILE = 2'h2;

  // ---------------------------------------------------------------
  // Host Wishbone register map
  // ---------------------------------------------------------------
  localparam logic [1:0] HREG_CTRL = 2'h0;
  localparam logic [1:0] HREG_WDATA = 2'h1;
  localparam logic [1:0] HREG_RDATA = 2'h2;
  localparam logic [1:0] HREG_STAT = 2'h3;
  localparam int CTL_GO = 0;
  localparam int CTL_WE = 1;
  localparam int CTL_ADDR_LSB = 4;
  localparam int CTL_CIA = 8;

endpackage : dcwd_pkg

//--- rtl/dcwd_link_if.sv
// Register link between the command master and the decoder
`timescale 1ns/1ns
interface dcwd_link_if;
  logic req;
  logic we;
  logic [dcwd_pkg::ADDR_W-1:0] addr;
  logic [dcwd_pkg::DATA_W-1:0] wdata;
  logic [dcwd_pkg::DATA_W-1:0] rdata;
  logic ack;

  modport dev (input req, input we, input addr, input wdata, output rdata, output ack);
  modport host (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface : dcwd_link_if

//--- rtl/dcwd_energy_digit.sv
// One 0..999 stage of the cascaded energy counter
`timescale 1ns/1ns
module dcwd_energy_digit #(
  parameter logic [9:0] MAX_COUNT = dcwd_pkg::ENERGY_MAX
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Count
  input wire logic inc_i,
  output logic [9:0] count_o,
  output logic carry_o
);
  typedef struct packed {
    logic [9:0] count;
  } dcwd_digit_t;

  dcwd_digit_t state_q;
  dcwd_digit_t state_d;

  // Zero would make the stage wrap on every tick
  if (MAX_COUNT == 10'h000) begin : g_bad_max
    $error("MAX_COUNT must be nonzero");
  end

  always_comb begin
    state_d = state_q;
    if (inc_i) begin
      state_d.count = (state_q.count == MAX_COUNT) ? dcwd_pkg::ENERGY_RESET : state_q.count + 10'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q.count <= dcwd_pkg::ENERGY_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign count_o = state_q.count;
  assign carry_o = inc_i && (state_q.count == MAX_COUNT);
endmodule : dcwd_energy_digit

//--- rtl/dcwd_host.sv
// Master end: Wishbone slave for software, drives the register link
`timescale 1ns/1ns
module dcwd_host (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Register link
  dcwd_link_if.host link
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } dcwd_host_st_t;

  typedef struct packed {
    dcwd_host_st_t st;
    logic ack;
    logic [31:0] dat;
    logic cia;
    logic we;
    logic [2:0] addr;
    logic [15:0] wdata;
    logic [15:0] link_wdata;
    logic [15:0] rdata;
  } dcwd_host_state_t;

  dcwd_host_state_t state_q;
  dcwd_host_state_t state_d;

  always_comb begin
    logic wr;
    logic [1:0] idx;
    wr = 1'b0;
    idx = wb_adr_i[3:2];
    state_d = state_q;

    // Ack one cycle after the request; write commits on the ack edge
    state_d.ack = wb_cyc_i && wb_stb_i && !state_q.ack;
    wr = wb_cyc_i && wb_stb_i && wb_we_i && state_q.ack;
    if (state_d.ack) begin
      unique case (idx)
        dcwd_pkg::HREG_CTRL: state_d.dat = {23'h000000, state_q.cia, 1'b0, state_q.addr, 2'h0, state_q.we, 1'b0};
        dcwd_pkg::HREG_WDATA: state_d.dat = {16'h0000, state_q.wdata};
        dcwd_pkg::HREG_RDATA: state_d.dat = {16'h0000, state_q.rdata};
        dcwd_pkg::HREG_STAT: state_d.dat = {31'h00000000, state_q.st == ST_BUSY};
      endcase
    end

    if (wr && idx == dcwd_pkg::HREG_WDATA) begin
      if (wb_sel_i[0]) begin
        state_d.wdata[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        state_d.wdata[15:8] = wb_dat_i[15:8];
      end
    end
    if (wr && idx == dcwd_pkg::HREG_CTRL && wb_sel_i[1]) begin
      state_d.cia = wb_dat_i[dcwd_pkg::CTL_CIA];
    end

    unique case (state_q.st)
      ST_IDLE: begin
        // A go while busy is ignored
        if (wr && idx == dcwd_pkg::HREG_CTRL && wb_sel_i[0] && wb_dat_i[dcwd_pkg::CTL_GO]) begin
          state_d.st = ST_BUSY;
          state_d.we = wb_dat_i[dcwd_pkg::CTL_WE];
          state_d.addr = wb_dat_i[dcwd_pkg::CTL_ADDR_LSB +: 3];
          // bits 0 to 3 pass unchanged
          state_d.link_wdata = state_q.wdata;
          // reserved bits forced low in CiA402
          // The mode bit written with this go already applies to this transfer
          if (state_d.cia) begin
            state_d.link_wdata = state_q.wdata & ~dcwd_pkg::RESERVED_MASK;
          end
        end
      end
      ST_BUSY: begin
        if (link.ack) begin
          state_d.st = ST_IDLE;
          state_d.rdata = link.rdata;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= '0;
      state_q.st <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign wb_ack_o = state_q.ack;
  assign wb_dat_o = state_q.dat;
  assign link.req = (state_q.st == ST_BUSY);
  assign link.we = state_q.we;
  assign link.addr = state_q.addr;
  assign link.wdata = state_q.link_wdata;
endmodule : dcwd_host

//--- test/dcwd_link_checker.sv
// Protocol and read-value checks on the register link between host and decoder
`timescale 1ns/1ns
module dcwd_link_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [dcwd_pkg::ADDR_W-1:0] addr_i,
  input wire logic [dcwd_pkg::DATA_W-1:0] wdata_i,
  input wire logic [dcwd_pkg::DATA_W-1:0] rdata_i,
  input wire logic ack_i
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------------
  // Handshake
  // ---------------------------------------------------------------
  a_ack_one_cycle: assert property ($rose(req_i) |=> ack_i)
    else $error("link ack not one cycle after request");
  a_ack_pulse: assert property (ack_i |=> !ack_i)
    else $error("link ack longer than one cycle");
  a_ack_with_req: assert property (ack_i |-> req_i)
    else $error("link ack without request");
  a_ack_cause: assert property (ack_i |-> $past(req_i) && !$past(ack_i))
    else $error("link ack without earlier request");
  a_req_hold: assert property (req_i && !ack_i |=> req_i)
    else $error("link request dropped before ack");
  a_req_release: assert property (ack_i |=> !req_i)
    else $error("link request kept after ack");
  a_req_stable: assert property (req_i && !ack_i |=> $stable(addr_i) && $stable(we_i) && $stable(wdata_i))
    else $error("link request changed while waiting");

  // ---------------------------------------------------------------
  // Read values
  // ---------------------------------------------------------------
  a_energy_range: assert property (ack_i && !we_i && addr_i <= dcwd_pkg::REG_ENERGY_WH |->
    rdata_i <= {6'h00, dcwd_pkg::ENERGY_MAX})
    else $error("energy counter above 999");
  a_source_code: assert property (ack_i && !we_i &&
    (addr_i == dcwd_pkg::REG_CMD_SOURCE || addr_i == dcwd_pkg::REG_REF_SOURCE) |-> rdata_i[15:2] == 14'h0000)
    else $error("channel code outside two bits");

  c_write: cover property (req_i && we_i && ack_i);
  c_word_read: cover property (ack_i && !we_i && addr_i == dcwd_pkg::REG_COMMAND_WORD);
  c_energy_read: cover property (ack_i && !we_i && addr_i == dcwd_pkg::REG_ENERGY_WH);
endmodule : dcwd_link_checker

//--- test/tb_drive_command_word_decoder.sv
// Self-checking bench: software Wishbone into host, host link into decoder
`timescale 1ns/1ns
module tb_drive_command_word_decoder;
  logic clk_i, rst_i, cyc, stb, we, fb, tick, three;
  logic [3:0] adr, sel;
  logic [31:0] dat, dat_o;
  logic [1:0] mode, csel, rsel, wch;
  logic [15:0] pre, r, w, prev, ub;
  logic ack_o, so, ve, qs, eo, fa, ha, fw, ra;
  int fail_count, checks_done, fa_n, fw_n, k, e;
  int ex[4];
  logic [15:0] seq[6] = '{16'h3, 16'h3, 16'h0, 16'h2, 16'h1, 16'h3};

  dcwd_link_if i_dcwd_link_if ();
  dcwd_host i_dcwd_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack_o), .link(i_dcwd_link_if));
  dcwd_device i_dcwd_device (.clk_i(clk_i), .rst_i(rst_i), .link(i_dcwd_link_if), .ctrl_mode_i(mode),
    .io_three_wire_i(three), .cmd_channel_sel_i(csel), .ref_channel_sel_i(rsel), .word_channel_i(wch),
    .fieldbus_present_i(fb), .energy_wh_tick_i(tick), .pre_ramp_ref_i(pre), .switch_on_o(so),
    .voltage_enable_o(ve), .quick_stop_o(qs), .enable_op_o(eo), .fault_ack_o(fa), .halt_o(ha),
    .io_forward_o(fw), .io_run_auth_o(ra), .user_bits_o(ub));
  dcwd_link_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .req_i(i_dcwd_link_if.req), .we_i(i_dcwd_link_if.we),
    .addr_i(i_dcwd_link_if.addr), .wdata_i(i_dcwd_link_if.wdata), .rdata_i(i_dcwd_link_if.rdata),
    .ack_i(i_dcwd_link_if.ack));

  always #2 clk_i = ~clk_i;
  // Pulse counters feed the edge models
  always @(posedge clk_i) begin
    if (fa === 1'b1) fa_n++;
    if (fw === 1'b1 && three === 1'b1) fw_n++;
  end

  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  // Waits for ack with no count of its own; only the watchdog ends a hang
  task wb(input logic w_i, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_i;
    adr <= a;
    sel <= 4'hf;
    dat <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // One link transfer through the host registers; busy polled until clear
  task lk(input logic w_i, input logic [2:0] a, input logic [15:0] d, input logic c, output logic [15:0] q);
    logic [31:0] x;
    wb(1'b1, 4'h4, {16'h0, d}, x);
    wb(1'b1, 4'h0, {23'h0, c, 1'b0, a, 2'b00, w_i, 1'b1}, x);
    x = 32'h1;
    while (x[0] !== 1'b0) begin
      wb(1'b0, 4'hc, 32'h0, x);
    end
    wb(1'b0, 4'h8, 32'h0, x);
    q = x[15:0];
  endtask : lk

  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    #240000;
    fail_count++;
    end_sim();
  end

  initial begin
    {clk_i, cyc, stb, we, fb, tick, three, mode, csel, rsel, wch} = '0;
    {adr, dat, pre} = '0;
    sel = 4'hf;
    rst_i = 1'b1;
    void'($urandom(93));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    pre <= 16'($urandom);
    // Reset values; a write to a read-only counter is dropped
    lk(1'b1, 3'h0, 16'h0123, 1'b0, r);
    for (int i = 0; i < 8; i++) begin
      lk(1'b0, i[2:0], 16'h0, 1'b0, r);
      chk("reset_read", r, (i == 7) ? pre : 16'h0);
    end
    $display("test reset done");
    // Channel codes, fieldbus only when present
    for (int s = 0; s < 8; s++) begin
      csel <= s[1:0];
      rsel <= ~s[1:0];
      fb <= s[2];
      lk(1'b0, 3'h4, 16'h0, 1'b0, r);
      chk("cmd_src", r, (s[1:0] == 2'h3 && !s[2]) ? 16'h0 : s[1:0]);
      lk(1'b0, 3'h6, 16'h0, 1'b0, r);
      chk("ref_src", r, (s[1:0] == 2'h0 && !s[2]) ? 16'h0 : {14'h0, ~s[1:0]});
    end
    $display("test channels done");
    // CiA402 decode in every non I/O mode
    for (int m = 0; m < 4; m++) begin
      if (m != 2) begin
        mode <= m[1:0];
        w = 16'($urandom);
        lk(1'b1, 3'h5, w, 1'b0, r);
        lk(1'b0, 3'h5, 16'h0, 1'b0, r);
        chk("word", r, w);
        chk("cia", {ha, eo, qs, ve, so}, {w[8], w[3], ~w[2], w[1], w[0]});
        chk("io_off", {fw, ra, ub}, {2'b00, w});
      end
    end
    mode <= 2'h0;
    lk(1'b1, 3'h5, 16'h0, 1'b0, r);
    fa_n = 0;
    lk(1'b1, 3'h5, 16'h0080, 1'b0, r);
    lk(1'b1, 3'h5, 16'h0080, 1'b0, r);
    chk("fault_ack", fa_n, 1);
    lk(1'b1, 3'h5, 16'hffff, 1'b1, r);
    lk(1'b0, 3'h5, 16'h0, 1'b0, r);
    chk("masked", r, 16'hffff & ~dcwd_pkg::RESERVED_MASK);
    $display("test cia done");
    // I/O two-wire forward level, only on the active channel
    mode <= 2'h2;
    csel <= 2'h1;
    wch <= 2'h1;
    lk(1'b1, 3'h5, 16'h0001, 1'b0, r);
    chk("fwd_2w", {fw, ha, eo, so}, 4'h8);
    wch <= 2'h2;
    repeat (4) @(posedge clk_i);
    chk("fwd_idle", fw, 1'b0);
    // Three-wire: forward only on a rising bit 1 with run authorised
    three <= 1'b1;
    wch <= 2'h1;
    lk(1'b1, 3'h5, 16'h0001, 1'b0, r);
    chk("run_auth", ra, 1'b1);
    fw_n = 0;
    e = 0;
    prev = 16'h0001;
    foreach (seq[i]) begin
      lk(1'b1, 3'h5, seq[i], 1'b0, r);
      if (seq[i][1] && !prev[1] && seq[i][0]) e++;
      prev = seq[i];
    end
    chk("fwd_3w", fw_n, e);
    $display("test io done");
    // Energy cascade across the Wh to kWh carry
    k = 1000 + $urandom % 200;
    repeat (k) begin
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
      @(posedge clk_i);
    end
    ex = '{0, 0, k / 1000, k % 1000};
    for (int i = 0; i < 4; i++) begin
      lk(1'b0, i[2:0], 16'h0, 1'b0, r);
      chk("energy", r, ex[i]);
    end
    $display("test energy done");
    end_sim();
  end
endmodule : tb_drive_command_word_decoder
